// ===== logic/scc_map.vh
// Constants for the switcher cycle controller
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

// Reference clock and oscillator
`define SCC_REF_HZ          20000000
`define SCC_OSC_HZ          132000
`define SCC_MAX_DUTY_PCT    65
`define SCC_SLOW_DIV        2

// Times in their own units
`define SCC_MIN_ON_NS       400
`define SCC_CHARGE_US       600
`define SCC_FAULT_MS        64
`define SCC_OFF_MS          2500

// Supply capacitor codes from the bypass sense
`define SCC_CAP_SMALL       2'h0
`define SCC_CAP_MIDDLE      2'h1
`define SCC_CAP_LARGE       2'h2
`define SCC_CHARGE_MUL_MID  26'h000_000a
`define SCC_CHARGE_MUL_LRG  26'h000_0064

// Current limit index levels and load steps
`define SCC_ILIM_REDUCED    3'h1
`define SCC_ILIM_STANDARD   3'h2
`define SCC_ILIM_INCREASED  3'h3
`define SCC_HIST_HEAVY      4'h6
`define SCC_HIST_MEDIUM     4'h3
`define SCC_STEP_NONE       2'h0
`define SCC_STEP_ONE        2'h1
`define SCC_STEP_TWO        2'h2
`define SCC_INC_LARGEST_MA  10'h352

// Control states
`define SCC_ST_CHARGE       2'h0
`define SCC_ST_UVWAIT       2'h1
`define SCC_ST_RUN          2'h2
`define SCC_ST_OFF          2'h3

`endif

// ===== logic/scc_osc.v
// Free-running cycle oscillator with max-duty window and slow mode
`timescale 1ns/1ps
`include "scc_map.vh"

module scc_osc (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Control
  input  wire       slow_req,
  // Outputs
  output reg        cycle_start,
  output reg        max_duty_signal
);

  localparam integer PERIOD_INT = `SCC_REF_HZ / `SCC_OSC_HZ;
  localparam integer DUTY_INT   = PERIOD_INT * `SCC_MAX_DUTY_PCT / 100;
  localparam integer SLOW_INT   = PERIOD_INT * `SCC_SLOW_DIV;
  localparam [9:0]   PERIOD     = PERIOD_INT[9:0];
  localparam [9:0]   DUTY       = DUTY_INT[9:0];
  localparam [9:0]   PERIOD_SLW = SLOW_INT[9:0];

  reg  [9:0]        cnt_r;
  reg  [9:0]        last_r;

  // Period is latched at each start so a mid-cycle request cannot cut it short
  always @(posedge clk) begin
    if (rst) begin
      cnt_r           <= 10'h000;
      last_r          <= PERIOD - 10'h001;
      cycle_start     <= 1'b0;
      max_duty_signal <= 1'b0;
    end else begin
      if (cnt_r >= last_r) begin
        cnt_r           <= 10'h000;
        cycle_start     <= 1'b1;
        max_duty_signal <= 1'b1;
        last_r          <= (slow_req ? PERIOD_SLW : PERIOD) - 10'h001;
      end else begin
        cnt_r       <= cnt_r + 10'h001;
        cycle_start <= 1'b0;
        if (cnt_r + 10'h001 >= DUTY) begin
          max_duty_signal <= 1'b0;
        end
      end
    end
  end

endmodule // scc_osc

// ===== logic/scc_top.v
// Cycle-by-cycle on/off control of the integrated power switch
`timescale 1ns/1ps
`include "scc_map.vh"

// How it works
// - Sampled enable high at cycle start turns the switch on that cycle.
// - Pulse ends at current limit or when max duty ends, whichever first.
// - A started cycle completes; enable changes ignored until next boundary.
// - Clock always runs; enable sampled for switching only at each cycle start.
// - Current limit level chosen from recent enable sample history.
// - Dense enables give highest limit; sparser ones step limit down further.
// - With line sensing, no switching at power-up until undervoltage clears.
// - Pulses shorter than 400 ns lower the switching frequency.
// - On power-down switch 64 ms more, then stay off during undervoltage.
// - Wait for supply capacitor charge, 0.6 ms scaled by capacitor size.
// - Base limit from capacitor: small standard, middle lower, large higher.
// - Smallest member has no increased limit; largest increased is 850 mA.
// - Fault counter cleared by enable low; 64 ms without gives 2.5 s off.
// - Oscillator at 132 kHz gives cycle start and max duty window.
// - Undervoltage blocks restart and stops the off counter meanwhile.
module scc_top #(
  parameter CHARGE_CYC      = `SCC_CHARGE_US * (`SCC_REF_HZ / 1000000),
  parameter FAULT_CYC       = `SCC_FAULT_MS * (`SCC_REF_HZ / 1000),
  parameter OFF_CYC         = `SCC_OFF_MS * (`SCC_REF_HZ / 1000),
  parameter FAMILY_SMALLEST = 0,
  parameter FAMILY_LARGEST  = 0
) (
  // Clock and reset
  input  wire       REF_CLK,
  input  wire       RST,
  // Feedback and line sense
  input  wire       FEEDBACK_ENABLE,
  input  wire       LINE_UV,
  input  wire       LINE_SENSE_PRESENT,
  // Analog sense flags
  input  wire       ILIM_REACHED,
  input  wire [1:0] BP_CAP_SIZE,
  // Switch and limit outputs
  output reg        GATE_ON,
  output reg  [2:0] ILIM_INDEX,
  output reg  [9:0] ILIM_INC_MA,
  output reg        SWITCHING_ACTIVE
);

  localparam integer CHARGE_INT  = CHARGE_CYC;
  localparam integer FAULT_INT   = FAULT_CYC - 1;
  localparam integer OFF_INT     = OFF_CYC - 1;
  localparam integer MIN_ON_INT  = (`SCC_MIN_ON_NS * (`SCC_REF_HZ / 1000000) + 999) / 1000;
  localparam [25:0]  CHARGE_BASE = CHARGE_INT[25:0];
  localparam [25:0]  FAULT_LAST  = FAULT_INT[25:0];
  localparam [25:0]  OFF_LAST    = OFF_INT[25:0];
  localparam [7:0]   MIN_ON_CYC  = MIN_ON_INT[7:0];

  // Two-flop synchronisers for all pin inputs except REF_CLK and RST
  reg  [5:0]        sync1_r;
  reg  [5:0]        sync2_r;
  wire              en_s      = sync2_r[0];
  wire              uv_s      = sync2_r[1];
  wire              sense_s   = sync2_r[2];
  wire              ilim_s    = sync2_r[3];
  wire [1:0]        cap_s     = sync2_r[5:4];
  wire              uv_block  = sense_s & uv_s;

  reg  [1:0]        state_r;
  reg  [25:0]       timer_r;
  reg  [1:0]        cap_sel_r;
  reg               cap_done_r;
  reg  [7:0]        on_cnt_r;
  reg               slow_r;
  reg  [7:0]        hist_r;
  reg  [1:0]        steps_r;
  reg  [7:0]        hist_nxt;

  wire              cyc_start;
  wire              max_duty;

  scc_osc u_osc (
    .clk             (REF_CLK),
    .rst             (RST),
    .slow_req        (slow_r),
    .cycle_start     (cyc_start),
    .max_duty_signal (max_duty)
  );

  // Count of enabled cycles in the history window
  function [3:0] ones8;
    input [7:0] v;
    integer i;
    begin
      ones8 = 4'h0;
      for (i = 0; i < 8; i = i + 1) begin
        ones8 = ones8 + {3'h0, v[i]};
      end
    end
  endfunction

  // Charge wait grows with the capacitor, as its charge time does
  function [25:0] charge_wait;
    input [1:0] sel;
    begin
      case (sel)
        `SCC_CAP_SMALL:  charge_wait = CHARGE_BASE;
        `SCC_CAP_MIDDLE: charge_wait = CHARGE_BASE * `SCC_CHARGE_MUL_MID;
        default:         charge_wait = CHARGE_BASE * `SCC_CHARGE_MUL_LRG;
      endcase
    end
  endfunction

  // Base limit index from the capacitor; no increased option on smallest member
  function [2:0] base_level;
    input [1:0] sel;
    begin
      case (sel)
        `SCC_CAP_SMALL:  base_level = `SCC_ILIM_STANDARD;
        `SCC_CAP_MIDDLE: base_level = `SCC_ILIM_REDUCED;
        default:         base_level = (FAMILY_SMALLEST != 0) ?
                                      `SCC_ILIM_STANDARD : `SCC_ILIM_INCREASED;
      endcase
    end
  endfunction

  always @* begin
    hist_nxt = {hist_r[6:0], en_s};
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= {BP_CAP_SIZE, ILIM_REACHED, LINE_SENSE_PRESENT, LINE_UV, FEEDBACK_ENABLE};
      sync2_r <= sync1_r;
    end
  end

  // Power-up, run, and auto-restart sequencing share one timer
  always @(posedge REF_CLK) begin
    if (RST) begin
      state_r    <= `SCC_ST_CHARGE;
      timer_r    <= 26'h000_0000;
      cap_sel_r  <= `SCC_CAP_SMALL;
      cap_done_r <= 1'b0;
    end else begin
      case (state_r)
        `SCC_ST_CHARGE: begin
          if (!cap_done_r) begin
            // Capacitor size caught once, after the synchronisers have filled
            if (timer_r >= 26'h000_0002) begin
              cap_sel_r  <= cap_s;
              cap_done_r <= 1'b1;
              timer_r    <= 26'h000_0000;
            end else begin
              timer_r <= timer_r + 26'h000_0001;
            end
          end else if (timer_r >= charge_wait(cap_sel_r) - 26'h000_0001) begin
            timer_r <= 26'h000_0000;
            state_r <= uv_block ? `SCC_ST_UVWAIT : `SCC_ST_RUN;
          end else begin
            timer_r <= timer_r + 26'h000_0001;
          end
        end
        `SCC_ST_UVWAIT: begin
          timer_r <= 26'h000_0000;
          if (!uv_block) begin
            state_r <= `SCC_ST_RUN;
          end
        end
        `SCC_ST_RUN: begin
          // Line undervoltage alone does not stop a running supply
          if (!en_s) begin
            timer_r <= 26'h000_0000;
          end else if (timer_r >= FAULT_LAST) begin
            timer_r <= 26'h000_0000;
            state_r <= `SCC_ST_OFF;
          end else begin
            timer_r <= timer_r + 26'h000_0001;
          end
        end
        `SCC_ST_OFF: begin
          if (uv_block) begin
            timer_r <= timer_r;
          end else if (timer_r >= OFF_LAST) begin
            timer_r <= 26'h000_0000;
            state_r <= `SCC_ST_RUN;
          end else begin
            timer_r <= timer_r + 26'h000_0001;
          end
        end
        default: begin
          state_r <= `SCC_ST_CHARGE;
          timer_r <= 26'h000_0000;
        end
      endcase
    end
  end

  // Switch pulse, on-time measure, and frequency fold-back request
  always @(posedge REF_CLK) begin
    if (RST) begin
      GATE_ON  <= 1'b0;
      on_cnt_r <= 8'h00;
      slow_r   <= 1'b0;
    end else if (state_r != `SCC_ST_RUN) begin
      GATE_ON  <= 1'b0;
      on_cnt_r <= 8'h00;
    end else if (cyc_start) begin
      // Enable is looked at here for the gate; the fault timer also sees it on every clock in RUN
      GATE_ON  <= en_s;
      on_cnt_r <= 8'h00;
    end else if (GATE_ON) begin
      if (ilim_s || !max_duty) begin
        GATE_ON <= 1'b0;
        slow_r  <= (on_cnt_r + 8'h01 < MIN_ON_CYC);
      end else if (on_cnt_r != 8'hff) begin
        on_cnt_r <= on_cnt_r + 8'h01;
      end
    end
  end

  // Load estimate from the enable history, updated once per cycle
  always @(posedge REF_CLK) begin
    if (RST) begin
      hist_r  <= 8'hff;
      steps_r <= `SCC_STEP_NONE;
    end else if (cyc_start && state_r == `SCC_ST_RUN) begin
      hist_r <= hist_nxt;
      if (ones8(hist_nxt) >= `SCC_HIST_HEAVY) begin
        steps_r <= `SCC_STEP_NONE;
      end else if (ones8(hist_nxt) >= `SCC_HIST_MEDIUM) begin
        steps_r <= `SCC_STEP_ONE;
      end else begin
        steps_r <= `SCC_STEP_TWO;
      end
    end
  end

  // Limit index to the current comparator, saturating at zero
  always @(posedge REF_CLK) begin
    if (RST) begin
      ILIM_INDEX       <= `SCC_ILIM_STANDARD;
      ILIM_INC_MA      <= 10'h000;
      SWITCHING_ACTIVE <= 1'b0;
    end else begin
      if (base_level(cap_sel_r) > {1'b0, steps_r}) begin
        ILIM_INDEX <= base_level(cap_sel_r) - {1'b0, steps_r};
      end else begin
        ILIM_INDEX <= 3'h0;
      end
      if (FAMILY_LARGEST != 0 && base_level(cap_sel_r) == `SCC_ILIM_INCREASED &&
          steps_r == `SCC_STEP_NONE) begin
        ILIM_INC_MA <= `SCC_INC_LARGEST_MA;
      end else begin
        ILIM_INC_MA <= 10'h000;
      end
      SWITCHING_ACTIVE <= (state_r == `SCC_ST_RUN);
    end
  end

endmodule // scc_top

// ===== testbench/scc_top_chk.sv
// Port checker for the cycle controller
`timescale 1ns/1ps
module scc_top_chk #(
  parameter CHARGE_CYC     = 20,
  parameter FAMILY_LARGEST = 0
) (
  input wire       REF_CLK,
  input wire       RST,
  input wire       FEEDBACK_ENABLE,
  input wire       LINE_UV,
  input wire       LINE_SENSE_PRESENT,
  input wire       ILIM_REACHED,
  input wire [1:0] BP_CAP_SIZE,
  input wire       GATE_ON,
  input wire [2:0] ILIM_INDEX,
  input wire [9:0] ILIM_INC_MA,
  input wire       SWITCHING_ACTIVE
);
  reg        gate_q_r;
  reg [9:0]  gap_r;
  reg [15:0] age_r;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Cycles since the last pulse start and since reset release
  always @(posedge REF_CLK) begin
    if (RST) begin
      gate_q_r <= 1'b0;
      gap_r    <= 10'h12c;
      age_r    <= 16'h0000;
    end else begin
      gate_q_r <= GATE_ON;
      // Restart only on a rising gate, not every cycle of a long pulse
      gap_r <= (GATE_ON && !gate_q_r) ? 10'h001 : gap_r + {9'h000, gap_r != 10'h3e8};
      age_r <= age_r + {15'h0000, age_r != 16'hffff};
    end
  end
  sequence s_rise;
    !GATE_ON ##1 GATE_ON;
  endsequence
  sequence s_trip;
    $rose(ILIM_REACHED) ##1 ILIM_REACHED [*2];
  endsequence
  a_reset_values: assert property (disable iff (1'b0) RST |=>
    !GATE_ON && !SWITCHING_ACTIVE && ILIM_INDEX == 3'h2) else $error("bad reset outputs");
  a_max_pulse: assert property ($rose(GATE_ON) |-> ##[1:100] !GATE_ON)
    else $error("pulse longer than max duty");
  a_ilim_ends: assert property (s_trip |-> ##[1:2] !GATE_ON)
    else $error("pulse kept after current limit");
  a_one_start: assert property (s_rise |-> gap_r >= 10'h096)
    else $error("two starts in one period");
  a_gate_idle: assert property (!SWITCHING_ACTIVE && $past(!SWITCHING_ACTIVE) |-> !GATE_ON)
    else $error("switching while stopped");
  a_charge_wait: assert property ($rose(SWITCHING_ACTIVE) |->
    age_r >= CHARGE_CYC * ((BP_CAP_SIZE == 2'h0) ? 1 : (BP_CAP_SIZE == 2'h1) ? 10 : 100))
    else $error("switching before charge wait");
  a_uv_hold: assert property ((LINE_SENSE_PRESENT && LINE_UV) [*4] ##0 !SWITCHING_ACTIVE
    |=> !SWITCHING_ACTIVE) else $error("restart during undervoltage");
  a_inc_level: assert property (ILIM_INC_MA ==
    ((FAMILY_LARGEST != 0 && ILIM_INDEX == 3'h3) ? 10'h352 : 10'h000))
    else $error("increased limit wrong");
  // Pin passes two sync flops, then the start edge launches the gate
  a_en_gates: assert property ($rose(GATE_ON) |-> $past(FEEDBACK_ENABLE, 3))
    else $error("pulse without enable");
  a_idx_bound: assert property (ILIM_INDEX <= 3'h3)
    else $error("limit index out of range");
endmodule // scc_top_chk
bind scc_top scc_top_chk #(.CHARGE_CYC(CHARGE_CYC), .FAMILY_LARGEST(FAMILY_LARGEST)) scc_top_chk_i (
  .REF_CLK(REF_CLK), .RST(RST), .FEEDBACK_ENABLE(FEEDBACK_ENABLE), .LINE_UV(LINE_UV),
  .LINE_SENSE_PRESENT(LINE_SENSE_PRESENT), .ILIM_REACHED(ILIM_REACHED),
  .BP_CAP_SIZE(BP_CAP_SIZE), .GATE_ON(GATE_ON), .ILIM_INDEX(ILIM_INDEX),
  .ILIM_INC_MA(ILIM_INC_MA), .SWITCHING_ACTIVE(SWITCHING_ACTIVE));

// ===== testbench/scc_opto_model.sv
// Secondary feedback model driving the enable input
`timescale 1ns/1ps
module scc_opto_model (
  input  wire       clk,
  input  wire       rst,
  input  wire       gate_on,
  input  wire [1:0] mode,
  output wire       fb_en
);
  reg       gate_q;
  reg [7:0] lvl_r;
  // Each pulse lifts the output, which then sags back
  always @(posedge clk) begin
    gate_q <= gate_on;
    if (rst) lvl_r <= 8'h00;
    else if (gate_q && !gate_on) lvl_r <= 8'hc0;
    else if (lvl_r != 8'h00) lvl_r <= lvl_r - 8'h01;
  end
  // Mode 1 open loop, 2 no load, 0 regulating
  assign fb_en = (mode == 2'h1) | ((mode == 2'h0) & (lvl_r < 8'h40));
endmodule // scc_opto_model

// ===== testbench/scc_top_tb_top.sv
// Self-checking bench for the cycle controller
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module scc_top_tb_top;
  reg         REF_CLK, RST, LINE_UV, LINE_SENSE_PRESENT;
  reg         ILIM_REACHED = 1'b0;
  reg  [1:0]  BP_CAP_SIZE, mode;
  reg  [31:0] seed = 32'h0000_002f;
  reg  [7:0]  on_cnt = 8'h00;
  reg  [7:0]  trip = 8'h10;
  wire        FEEDBACK_ENABLE, GATE_ON, SWITCHING_ACTIVE;
  wire [2:0]  ILIM_INDEX;
  wire [9:0]  ILIM_INC_MA;
  int         bad_count, check_count, c, k;
  scc_top #(.CHARGE_CYC(20), .FAULT_CYC(2000), .OFF_CYC(600), .FAMILY_LARGEST(1)) scc_top_i (
    .REF_CLK(REF_CLK), .RST(RST), .FEEDBACK_ENABLE(FEEDBACK_ENABLE), .LINE_UV(LINE_UV),
    .LINE_SENSE_PRESENT(LINE_SENSE_PRESENT), .ILIM_REACHED(ILIM_REACHED),
    .BP_CAP_SIZE(BP_CAP_SIZE), .GATE_ON(GATE_ON), .ILIM_INDEX(ILIM_INDEX),
    .ILIM_INC_MA(ILIM_INC_MA), .SWITCHING_ACTIVE(SWITCHING_ACTIVE));
  scc_opto_model scc_opto_model_i (.clk(REF_CLK), .rst(RST), .gate_on(GATE_ON),
    .mode(mode), .fb_en(FEEDBACK_ENABLE));
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  function [2:0] cap_base(input int cc);
    cap_base = (cc == 0) ? 3'h2 : (cc == 1) ? 3'h1 : 3'h3;
  endfunction
  function [9:0] inc_exp(input int cc);
    inc_exp = (cc >= 2) ? 10'h352 : 10'h000;
  endfunction
  function int chg(input int cc);
    chg = (cc == 0) ? 20 : (cc == 1) ? 200 : 2000;
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  task do_reset(input [1:0] cap);
    BP_CAP_SIZE <= cap;
    RST <= 1'b1;
    cyc(3);
    RST <= 1'b0;
  endtask
  task wait_act(input bit val, input int lim);
    for (k = 0; k < lim && SWITCHING_ACTIVE !== val; k++) cyc(1);
  endtask
  task stop_test;
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  // Current comparator trips after a random on-time, short ones included
  always @(posedge REF_CLK) begin
    on_cnt <= GATE_ON ? on_cnt + 8'h01 : 8'h00;
    if (!GATE_ON) seed <= xs(seed);
    if (!GATE_ON) trip <= {2'h0, seed[5:0]};
    ILIM_REACHED <= GATE_ON && on_cnt >= trip;
  end
  initial begin
    #3_000_000;
    bad_count++;
    stop_test;
  end
  initial begin
    RST = 1'b1;
    LINE_UV = 1'b0;
    LINE_SENSE_PRESENT = 1'b0;
    BP_CAP_SIZE = 2'h0;
    mode = 2'h1;
    cyc(1);
    for (c = 0; c < 4; c++) begin
      do_reset(c[1:0]);
      `CHK(ILIM_INDEX, 3'h2)
      cyc(chg(c));
      `CHK(SWITCHING_ACTIVE, 1'b0)
      wait_act(1'b1, 20);
      `CHK(SWITCHING_ACTIVE, 1'b1)
      cyc(2);
      `CHK(ILIM_INDEX, cap_base(c))
      `CHK(ILIM_INC_MA, inc_exp(c))
    end
    do_reset(2'h0);
    mode <= 2'h0;
    cyc(3000);
    `CHK(SWITCHING_ACTIVE, 1'b1)
    mode <= 2'h2;
    // Six empty samples at the slow period of up to 302 cycles
    cyc(2200);
    `CHK(ILIM_INDEX, 3'h0)
    `CHK(GATE_ON, 1'b0)
    mode <= 2'h1;
    // Long enough for six samples, short of the fault timeout
    cyc(1900);
    `CHK(ILIM_INDEX, 3'h2)
    wait_act(1'b0, 800);
    `CHK(SWITCHING_ACTIVE, 1'b0)
    wait_act(1'b1, 700);
    `CHK(SWITCHING_ACTIVE, 1'b1)
    LINE_SENSE_PRESENT <= 1'b1;
    LINE_UV <= 1'b1;
    do_reset(2'h0);
    cyc(300);
    `CHK(SWITCHING_ACTIVE, 1'b0)
    LINE_UV <= 1'b0;
    wait_act(1'b1, 20);
    `CHK(SWITCHING_ACTIVE, 1'b1)
    LINE_UV <= 1'b1;
    cyc(100);
    `CHK(SWITCHING_ACTIVE, 1'b1)
    wait_act(1'b0, 2100);
    `CHK(SWITCHING_ACTIVE, 1'b0)
    cyc(1000);
    `CHK(SWITCHING_ACTIVE, 1'b0)
    LINE_UV <= 1'b0;
    wait_act(1'b1, 700);
    `CHK(SWITCHING_ACTIVE, 1'b1)
    stop_test;
  end
endmodule // scc_top_tb_top
